// ### src/scbbe_core.v
/*
 Execution slice: arithmetic shift, add with carry, bit clear,
 bit test skips and relative jump, driven over AXI4-Lite.
 Assumes one clock, asynchronous active-low reset, AXI4-Lite master.
*/
`timescale 1ns/1ns
`include "scbbe_consts.vh"

// Summary of operation
// - Arithmetic shift moves bits 7..1 down one place and keeps bit 7.
// - Arithmetic shift loads operand bit 0 into carry; carry and zero updated.
// - Shift and add: destination bit 0 writes the accumulator, 1 writes the file register; bit clear always writes the file register.
// - Add with carry sums accumulator, file register and carry; sets C, DC, Z.
// - Bit clear zeroes the chosen bit, keeps the rest, touches no flag.
// - Skip when bit low: a zero bit discards next instruction, two cycles.
// - Skip when bit high: a one bit discards next instruction, two cycles.
// - Relative jump adds signed 9-bit offset to incremented program counter.
// - Relative jump always takes two cycles and leaves the flags alone.
// - Bit selector is 3 bits, file address is 7 bits.
module scbbe_core #(
   parameter PC_W = 15
) (
   input  wire                    clock,
   input  wire                    rst_b,
   input  wire [`SCBBE_AXI_AW-1:0] s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output reg                     s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output reg                     s_axi_wready,
   output reg  [1:0]              s_axi_bresp,
   output reg                     s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`SCBBE_AXI_AW-1:0] s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output reg                     s_axi_arready,
   output reg  [31:0]             s_axi_rdata,
   output reg  [1:0]              s_axi_rresp,
   output reg                     s_axi_rvalid,
   input  wire                    s_axi_rready
);

   // ****************************************
   // States
   // ****************************************
   localparam S_IDLE    = 7'b0000001;
   localparam S_RD_WAIT = 7'b0000010;
   localparam S_RRESP   = 7'b0000100;
   localparam S_BRESP   = 7'b0001000;
   localparam S_EX_RD   = 7'b0010000;
   localparam S_EX_DO   = 7'b0100000;
   localparam S_EX_SLOT = 7'b1000000;

   reg  [6:0]               state;
   reg                      aw_got;
   reg                      w_got;
   reg                      ar_got;
   reg  [`SCBBE_AXI_AW-1:0] wr_addr;
   reg  [31:0]              wr_data;
   reg  [3:0]               wr_strb;
   reg  [`SCBBE_AXI_AW-1:0] rd_addr;
   reg  [7:0]               acc;
   reg                      flag_c;
   reg                      nibble_carry_flag;
   reg                      flag_z;
   reg  [PC_W-1:0]          program_counter;
   reg  [2:0]               cmd_op;
   reg                      cmd_dest;
   reg  [2:0]               cmd_bit;
   reg  [6:0]               cmd_faddr;
   reg  [8:0]               cmd_offs;
   reg                      last_slot;
   reg  [1:0]               last_cycles;

   wire [7:0]               mem_rdata;
   wire                     mem_we;
   wire [6:0]               mem_addr;
   wire [7:0]               mem_wdata;

   // ****************************************
   // Write decode and byte merge
   // ****************************************
   wire        wr_go   = (state == S_IDLE) & aw_got & w_got;
   wire        rd_go   = (state == S_IDLE) & ar_got & ~(aw_got & w_got);
   wire        wr_win  = ((wr_addr & `SCBBE_WIN_MASK) == `SCBBE_WIN_BASE);
   wire        rd_win  = ((rd_addr & `SCBBE_WIN_MASK) == `SCBBE_WIN_BASE);
   wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                            {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire [31:0] cmd_cur = {7'h00, cmd_offs, 1'b0, cmd_faddr,
                          1'b0, cmd_bit, cmd_dest, cmd_op};
   wire [31:0] stat_cur = {26'h0, last_cycles, last_slot,
                           flag_z, nibble_carry_flag, flag_c};
   wire [31:0] pc_cur  = {{(32-PC_W){1'b0}}, program_counter};
   wire [31:0] acc_cur = {24'h0, acc};
   wire [31:0] new_cmd = (wr_data & strb_mask) | (cmd_cur & ~strb_mask);
   wire [31:0] new_st  = (wr_data & strb_mask) | (stat_cur & ~strb_mask);
   wire [31:0] new_pc  = (wr_data & strb_mask) | (pc_cur & ~strb_mask);
   wire [31:0] new_acc = (wr_data & strb_mask) | (acc_cur & ~strb_mask);
   wire [2:0]  new_op  = new_cmd[`SCBBE_CMD_OP_LSB +: 3];

   // ****************************************
   // Operand and result datapath
   // ****************************************
   wire [7:0]  res_asr  = {mem_rdata[7], mem_rdata[7:1]};
   wire [8:0]  sum9     = {1'b0, acc} + {1'b0, mem_rdata} + {8'h00, flag_c};
   wire [4:0]  nib5     = {1'b0, acc[3:0]} + {1'b0, mem_rdata[3:0]}
                        + {4'h0, flag_c};
   wire [7:0]  res_bclr = mem_rdata & ~(8'h01 << cmd_bit);
   wire        bit_val  = mem_rdata[cmd_bit];
   wire        is_asr   = (cmd_op == `SCBBE_OP_ASR);
   wire        is_addc  = (cmd_op == `SCBBE_OP_ADDC);
   wire        is_bclr  = (cmd_op == `SCBBE_OP_BCLR);
   wire        is_jump  = (cmd_op == `SCBBE_OP_JUMP);
   wire        skip_hit = ((cmd_op == `SCBBE_OP_SKLO) & ~bit_val)
                        | ((cmd_op == `SCBBE_OP_SKHI) & bit_val);
   wire        ex_slot  = skip_hit | is_jump;
   wire [7:0]  ex_res   = is_asr ? res_asr : (is_addc ? sum9[7:0] : res_bclr);
   wire        file_wr  = ((is_asr | is_addc) & cmd_dest) | is_bclr;
   wire [PC_W-1:0] pc_inc  = program_counter + {{(PC_W-1){1'b0}}, 1'b1};
   wire [PC_W-1:0] pc_skip = pc_inc + {{(PC_W-1){1'b0}}, 1'b1};
   wire [PC_W-1:0] pc_jump = pc_inc + {{(PC_W-9){cmd_offs[8]}}, cmd_offs};

   // ****************************************
   // File memory port
   // ****************************************
   assign mem_addr  = (state == S_EX_RD || state == S_EX_DO) ? cmd_faddr :
                      (wr_go ? wr_addr[8:2] : rd_addr[8:2]);
   assign mem_we    = (wr_go & wr_win & wr_strb[0])
                    | ((state == S_EX_DO) & file_wr);
   assign mem_wdata = (state == S_EX_DO) ? ex_res : wr_data[7:0];

   scbbe_file_mem #(
      .AW (7),
      .DW (8)
   ) u_file_mem (
      .clock (clock),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );

   // ****************************************
   // Channel capture
   // ****************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         ar_got        <= 1'b0;
         wr_addr       <= {`SCBBE_AXI_AW{1'b0}};
         wr_data       <= 32'h0;
         wr_strb       <= 4'h0;
         rd_addr       <= {`SCBBE_AXI_AW{1'b0}};
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b1;
            wr_addr       <= s_axi_awaddr;
         end else if (s_axi_awvalid && !aw_got && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
         end else if (s_axi_wvalid && !w_got && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            ar_got        <= 1'b1;
            rd_addr       <= s_axi_araddr;
         end else if (s_axi_arvalid && !ar_got && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
         end
         if (state == S_BRESP && s_axi_bready) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
         end
         if (state == S_RRESP && s_axi_rready) begin
            ar_got <= 1'b0;
         end
      end
   end

   // ****************************************
   // Sequencer: bus access and execution
   // ****************************************
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state             <= S_IDLE;
         s_axi_bvalid      <= 1'b0;
         s_axi_bresp       <= `SCBBE_RESP_OK;
         s_axi_rvalid      <= 1'b0;
         s_axi_rresp       <= `SCBBE_RESP_OK;
         s_axi_rdata       <= 32'h0;
         acc               <= `SCBBE_RST_ACC;
         flag_c            <= 1'b0;
         nibble_carry_flag <= 1'b0;
         flag_z            <= 1'b0;
         program_counter   <= {PC_W{1'b0}};
         cmd_op            <= `SCBBE_OP_ASR;
         cmd_dest          <= 1'b0;
         cmd_bit           <= 3'h0;
         cmd_faddr         <= 7'h00;
         cmd_offs          <= 9'h000;
         last_slot         <= 1'b0;
         last_cycles       <= `SCBBE_RST_CYC;
      end else begin
         case (state)
            S_IDLE: begin
               if (wr_go) begin
                  s_axi_bresp <= `SCBBE_RESP_OK;
                  s_axi_bvalid <= 1'b1;
                  state <= S_BRESP;
                  if (wr_win) begin
                     state <= S_BRESP;
                  end else if (wr_addr == `SCBBE_OFF_CMD) begin
                     cmd_op    <= new_op;
                     cmd_dest  <= new_cmd[`SCBBE_CMD_DEST_BIT];
                     cmd_bit   <= new_cmd[`SCBBE_CMD_BIT_LSB +: 3];
                     cmd_faddr <= new_cmd[`SCBBE_CMD_FA_LSB +: 7];
                     cmd_offs  <= new_cmd[`SCBBE_CMD_OFS_LSB +: 9];
                     if (new_op > `SCBBE_OP_LAST) begin
                        s_axi_bresp <= `SCBBE_RESP_ERR;
                     end else begin
                        s_axi_bvalid <= 1'b0;
                        state <= S_EX_RD;
                     end
                  end else if (wr_addr == `SCBBE_OFF_ACC) begin
                     acc <= new_acc[7:0];
                  end else if (wr_addr == `SCBBE_OFF_STATUS) begin
                     flag_c            <= new_st[`SCBBE_ST_C];
                     nibble_carry_flag <= new_st[`SCBBE_ST_DC];
                     flag_z            <= new_st[`SCBBE_ST_Z];
                  end else if (wr_addr == `SCBBE_OFF_PC) begin
                     program_counter <= new_pc[PC_W-1:0];
                  end else begin
                     s_axi_bresp <= `SCBBE_RESP_ERR;
                  end
               end else if (rd_go) begin
                  if (rd_win) begin
                     state <= S_RD_WAIT;
                  end else begin
                     s_axi_rvalid <= 1'b1;
                     s_axi_rresp  <= `SCBBE_RESP_OK;
                     state        <= S_RRESP;
                     if (rd_addr == `SCBBE_OFF_CMD) begin
                        s_axi_rdata <= cmd_cur;
                     end else if (rd_addr == `SCBBE_OFF_ACC) begin
                        s_axi_rdata <= acc_cur;
                     end else if (rd_addr == `SCBBE_OFF_STATUS) begin
                        s_axi_rdata <= stat_cur;
                     end else if (rd_addr == `SCBBE_OFF_PC) begin
                        s_axi_rdata <= pc_cur;
                     end else begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `SCBBE_RESP_ERR;
                     end
                  end
               end
            end
            S_RD_WAIT: begin
               s_axi_rdata  <= {24'h0, mem_rdata};
               s_axi_rresp  <= `SCBBE_RESP_OK;
               s_axi_rvalid <= 1'b1;
               state        <= S_RRESP;
            end
            S_RRESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  state        <= S_IDLE;
               end
            end
            S_BRESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  state        <= S_IDLE;
               end
            end
            S_EX_RD: begin
               state <= S_EX_DO;
            end
            S_EX_DO: begin
               if (is_asr) begin
                  flag_c <= mem_rdata[0];
                  flag_z <= (res_asr == 8'h00);
                  if (!cmd_dest) begin
                     acc <= res_asr;
                  end
               end
               if (is_addc) begin
                  flag_c            <= sum9[8];
                  nibble_carry_flag <= nib5[4];
                  flag_z            <= (sum9[7:0] == 8'h00);
                  if (!cmd_dest) begin
                     acc <= sum9[7:0];
                  end
               end
               if (is_jump) begin
                  program_counter <= pc_jump;
               end else if (skip_hit) begin
                  program_counter <= pc_skip;
               end else begin
                  program_counter <= pc_inc;
               end
               last_slot <= ex_slot;
               if (ex_slot) begin
                  last_cycles <= `SCBBE_CYC_TWO;
                  state       <= S_EX_SLOT;
               end else begin
                  last_cycles  <= `SCBBE_CYC_ONE;
                  s_axi_bresp  <= `SCBBE_RESP_OK;
                  s_axi_bvalid <= 1'b1;
                  state        <= S_BRESP;
               end
            end
            S_EX_SLOT: begin
               // Idle slot in place of the discarded instruction
               s_axi_bresp  <= `SCBBE_RESP_OK;
               s_axi_bvalid <= 1'b1;
               state        <= S_BRESP;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// ### src/scbbe_consts.vh
/*
 Constants for the shift, carry, bit and branch execution slice.
 Assumes inclusion by the core, the checker and the bench; definitions only.
*/
`ifndef SCBBE_CONSTS_VH
`define SCBBE_CONSTS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define SCBBE_AXI_AW     12
`define SCBBE_OFF_CMD    12'h000
`define SCBBE_OFF_ACC    12'h004
`define SCBBE_OFF_STATUS 12'h008
`define SCBBE_OFF_PC     12'h00c
`define SCBBE_WIN_BASE   12'h200
`define SCBBE_WIN_MASK   12'he00

// ****************************************
// Command word fields
// ****************************************
`define SCBBE_CMD_OP_LSB   0
`define SCBBE_CMD_DEST_BIT 3
`define SCBBE_CMD_BIT_LSB  4
`define SCBBE_CMD_FA_LSB   8
`define SCBBE_CMD_OFS_LSB  16

// ****************************************
// Operation codes
// ****************************************
`define SCBBE_OP_ASR   3'h0
`define SCBBE_OP_ADDC  3'h1
`define SCBBE_OP_BCLR  3'h2
`define SCBBE_OP_SKLO  3'h3
`define SCBBE_OP_SKHI  3'h4
`define SCBBE_OP_JUMP  3'h5
`define SCBBE_OP_LAST  3'h5

// ****************************************
// Status fields, reset values, responses
// ****************************************
`define SCBBE_ST_C     0
`define SCBBE_ST_DC    1
`define SCBBE_ST_Z     2
`define SCBBE_ST_SLOT  3
`define SCBBE_ST_CYC   4
`define SCBBE_RST_ACC  8'h00
`define SCBBE_RST_CYC  2'h0
`define SCBBE_CYC_ONE  2'h1
`define SCBBE_CYC_TWO  2'h2
`define SCBBE_RESP_OK  2'h0
`define SCBBE_RESP_ERR 2'h2

`endif

// ### src/scbbe_file_mem.v
/*
 File register memory, one port, read data from a register.
 Assumes a single clock; contents are not reset.
*/
`timescale 1ns/1ns

module scbbe_file_mem #(
   parameter AW = 7,
   parameter DW = 8
) (
   input  wire          clock,
   input  wire          we,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output reg  [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // ****************************************
   // Read before write
   // ****************************************
   always @(posedge clock) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule

// ### tb/scbbe_assertions.sv
/*
 Checker for scbbe_core: bus response timing and instruction latency.
 Assumes it is bound to scbbe_core and sees only that module's ports.
*/
`timescale 1ns/1ns
`include "scbbe_consts.vh"

module scbbe_chk (
   input wire                     clock,
   input wire                     rst_b,
   input wire [`SCBBE_AXI_AW-1:0] s_axi_awaddr,
   input wire                     s_axi_awvalid,
   input wire                     s_axi_awready,
   input wire [31:0]              s_axi_wdata,
   input wire [3:0]               s_axi_wstrb,
   input wire                     s_axi_wvalid,
   input wire                     s_axi_wready,
   input wire [1:0]               s_axi_bresp,
   input wire                     s_axi_bvalid,
   input wire                     s_axi_bready,
   input wire [`SCBBE_AXI_AW-1:0] s_axi_araddr,
   input wire                     s_axi_arvalid,
   input wire                     s_axi_arready,
   input wire [31:0]              s_axi_rdata,
   input wire [1:0]               s_axi_rresp,
   input wire                     s_axi_rvalid,
   input wire                     s_axi_rready
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // ********************
   // Command steps
   // ********************
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         && s_axi_awaddr == `SCBBE_OFF_CMD;
   endsequence
   sequence quiet3_s;
      !s_axi_bvalid [*3];
   endsequence

   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped early");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready longer than one cycle");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      && (s_axi_araddr & `SCBBE_WIN_MASK) != `SCBBE_WIN_BASE |-> ##2 s_axi_rvalid)
      else $error("register read answer late");
   win_answer_a: assert property (s_axi_arvalid && s_axi_arready
      && (s_axi_araddr & `SCBBE_WIN_MASK) == `SCBBE_WIN_BASE |-> ##3 s_axi_rvalid)
      else $error("file read answer late");
   err_zero_a: assert property (s_axi_rvalid && s_axi_rresp != `SCBBE_RESP_OK |->
      s_axi_rdata == 32'h0) else $error("refused read carries data");
   busy_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   step_one_a: assert property (wr_take_s ##0 (s_axi_wdata[2:0] <= `SCBBE_OP_BCLR) |=>
      !s_axi_bvalid [*2] ##[1:2] s_axi_bvalid) else $error("single step latency wrong");
   jump_two_a: assert property (
      wr_take_s ##0 (s_axi_wdata[2:0] == `SCBBE_OP_JUMP) |=> quiet3_s ##[1:2] s_axi_bvalid)
      else $error("jump latency wrong");
   bad_op_a: assert property (wr_take_s ##0 (s_axi_wdata[2:0] > `SCBBE_OP_LAST) |->
      ##[1:4] (s_axi_bvalid && s_axi_bresp == `SCBBE_RESP_ERR))
      else $error("illegal operation not refused");
endmodule

bind scbbe_core scbbe_chk u_chk (.clock(clock), .rst_b(rst_b),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### tb/test_shift_carry_bit_branch_exec.sv
/*
 Self-checking bench for scbbe_core: registers, every operation, skips and jumps.
 Assumes scbbe_consts.vh on the include path and the checker bound alongside.
*/
`timescale 1ns/1ns
`include "scbbe_consts.vh"

module test_shift_carry_bit_branch_exec;
   localparam PW = 15;
   localparam [11:0] a_cmd  = `SCBBE_OFF_CMD;
   localparam [11:0] a_acc  = `SCBBE_OFF_ACC;
   localparam [11:0] a_st   = `SCBBE_OFF_STATUS;
   localparam [11:0] a_prog = `SCBBE_OFF_PC;
   logic        clock = 1'b0, rst_b = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rdat;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   int          failures = 0, n_compared = 0, stall = 0;

   always #4 clock = ~clock;

   scbbe_core #(.PC_W(PW)) DUT (.clock(clock), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // ********************
   // Bus and compare tasks
   // ********************
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared++;
         if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [11:0] a, input [31:0] d);
      logic ad, wdn;
      begin
         ad = 1'b0;
         wdn = 1'b0;
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         while (!(ad && wdn)) begin
            @(posedge clock);
            if (awready === 1'b1 && !ad) begin
               ad = 1'b1;
               awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !wdn) begin
               wdn = 1'b1;
               wvalid <= 1'b0;
            end
         end
         repeat (stall) @(posedge clock);
         bready <= 1'b1;
         do @(posedge clock); while (bvalid !== 1'b1);
         rsp = bresp;
         bready <= 1'b0;
         @(posedge clock);
      end
   endtask

   task rd(input [11:0] a);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         do @(posedge clock); while (arready !== 1'b1);
         arvalid <= 1'b0;
         repeat (stall) @(posedge clock);
         rready <= 1'b1;
         do @(posedge clock); while (rvalid !== 1'b1);
         rdat = rdata;
         rsp = rresp;
         rready <= 1'b0;
         @(posedge clock);
      end
   endtask

   function [11:0] fa(input [6:0] f);
      fa = `SCBBE_WIN_BASE + {3'h0, f, 2'h0};
   endfunction

   task chkr(input [11:0] a, input [31:0] e);
      begin
         rd(a);
         chk(rdat, e);
      end
   endtask

   task fw(input [6:0] f, input [7:0] v);
      wr(fa(f), {24'h0, v});
   endtask

   task ex(input [2:0] op, input d, input [2:0] b, input [6:0] f, input [8:0] k);
      begin
         wr(a_cmd, {7'h0, k, 1'b0, f, 1'b0, b, d, op});
         chk({30'h0, rsp}, op > `SCBBE_OP_LAST ? `SCBBE_RESP_ERR : `SCBBE_RESP_OK);
      end
   endtask

   // ********************
   // Scenarios
   // ********************
   task t_regs;
      int i;
      begin
         for (i = 0; i < 4; i++) chkr(12'(i * 4), 32'h0);
         stall = 3;
         rd(12'h010);
         chk({30'h0, rsp}, `SCBBE_RESP_ERR);
         chk(rdat, 32'h0);
         wr(12'h010, 32'hffff_ffff);
         chk({30'h0, rsp}, `SCBBE_RESP_ERR);
         stall = 0;
      end
   endtask

   task t_shift;
      begin
         wr(a_st, 32'h2);
         fw(7'h05, 8'h81);
         ex(`SCBBE_OP_ASR, 1'b0, 3'h0, 7'h05, 9'h0);
         chkr(a_acc, 32'hc0);
         chkr(a_st, 32'h13);
         chkr(fa(7'h05), 32'h81);
         fw(7'h06, 8'h01);
         ex(`SCBBE_OP_ASR, 1'b1, 3'h0, 7'h06, 9'h0);
         chkr(fa(7'h06), 32'h0);
         chkr(a_st, 32'h17);
         fw(7'h07, 8'h7e);
         ex(`SCBBE_OP_ASR, 1'b0, 3'h0, 7'h07, 9'h0);
         chkr(a_acc, 32'h3f);
         chkr(a_st, 32'h12);
      end
   endtask

   task t_add(input [7:0] acc, input [7:0] f, input [1:0] c, input d,
              input [7:0] res, input [31:0] st);
      begin
         wr(a_acc, {24'h0, acc});
         wr(a_st, {30'h0, c});
         fw(7'h08, f);
         ex(`SCBBE_OP_ADDC, d, 3'h0, 7'h08, 9'h0);
         chkr(d ? fa(7'h08) : a_acc, {24'h0, res});
         chkr(d ? a_acc : fa(7'h08), {24'h0, d ? acc : f});
         chkr(a_st, st);
      end
   endtask

   task t_bclr;
      int i;
      begin
         wr(a_acc, 32'h5a);
         wr(a_st, 32'h7);
         for (i = 0; i < 8; i++) begin
            fw(7'h7f, 8'hff);
            ex(`SCBBE_OP_BCLR, 1'b0, 3'(i), 7'h7f, 9'h0);
            chkr(fa(7'h7f), {24'h0, ~(8'h01 << i)});
            chkr(a_st, 32'h17);
         end
         chkr(a_acc, 32'h5a);
      end
   endtask

   task t_skip;
      int i;
      logic [2:0] b;
      logic v, tk;
      begin
         for (i = 0; i < 4; i++) begin
            b = 3'(i * 2 + 1);
            v = i[0];
            tk = i[1] ? v : !v;
            fw(7'h03, v ? 8'h01 << b : ~(8'h01 << b));
            wr(a_prog, 32'h10);
            wr(a_st, 32'h5);
            ex(i[1] ? `SCBBE_OP_SKHI : `SCBBE_OP_SKLO, 1'b0, b, 7'h03, 9'h0);
            chkr(a_prog, tk ? 32'h12 : 32'h11);
            chkr(a_st, tk ? 32'h2d : 32'h15);
         end
      end
   endtask

   task t_jump;
      logic [14:0] start [5] = '{15'h10, 15'h200, 15'h0, 15'h7fff, 15'h20};
      logic [8:0] ks [5] = '{9'h0ff, 9'h100, 9'h100, 9'h000, 9'h1ff};
      logic [14:0] e;
      int i;
      begin
         for (i = 0; i < 5; i++) begin
            wr(a_prog, {17'h0, start[i]});
            wr(a_st, 32'h7);
            ex(`SCBBE_OP_JUMP, 1'b0, 3'h0, 7'h0, ks[i]);
            e = start[i] + 15'h1 + {{6{ks[i][8]}}, ks[i]};
            chkr(a_prog, {17'h0, e});
            rd(a_st);
            chk(rdat, 32'h2f);
         end
      end
   endtask

   task t_badop;
      begin
         wr(a_acc, 32'h33);
         wr(a_prog, 32'h44);
         ex(3'h6, 1'b1, 3'h0, 7'h0, 9'h0);
         ex(3'h7, 1'b0, 3'h0, 7'h0, 9'h0);
         chkr(a_acc, 32'h33);
         chkr(a_prog, 32'h44);
         // Partial strobe merges only byte 1
         wstrb <= 4'h2;
         wr(a_prog, 32'h1234_5678);
         chk({30'h0, rsp}, `SCBBE_RESP_OK);
         wstrb <= 4'hf;
         chkr(a_prog, 32'h5644);
      end
   endtask

   task summarize;
      begin
         $display("compared %0d failures %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask

   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      t_regs;
      t_shift;
      t_add(8'h0f, 8'h01, 2'h1, 1'b0, 8'h11, 32'h12);
      t_add(8'hff, 8'h00, 2'h1, 1'b1, 8'h00, 32'h17);
      t_add(8'h80, 8'h80, 2'h0, 1'b0, 8'h00, 32'h15);
      t_bclr;
      t_skip;
      t_jump;
      t_badop;
      summarize;
   end

   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      $display("BAD %0t watchdog expired", $time);
      summarize;
   end
endmodule
